// ==== include/setup_switch_pkg.sv ====
// package: constants and types for the setup switch decoder
package setup_switch_pkg;

	// ----------------------------------------
	// AXI4-Lite register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_MODE     = 8'h04;
	localparam logic [7:0] ADDR_RUN      = 8'h08;
	localparam logic [7:0] ADDR_NETADDR  = 8'h0C;
	localparam logic [7:0] ADDR_DRIVE    = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;

	// CTRL fields (write): monitor commands, self-clearing
	localparam int CTRL_MON_OFF_BIT = 0;
	localparam int CTRL_MON_ON_BIT  = 1;

	// STATUS fields
	localparam int STAT_MON_EN_BIT   = 0;
	localparam int STAT_SW1_ERR_BIT  = 1;
	localparam int STAT_NET_VALID_BIT = 2;
	localparam int STAT_STABLE_BIT   = 3;
	localparam int STAT_LATCHED_BIT  = 4;

	// DRIVE fields
	localparam int DRV_HALF_BIT  = 8;
	localparam int DRV_CCW_BIT   = 9;
	localparam int DRV_POWER_BIT = 10;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ          = 10_000_000;
	localparam int SETTLE_US       = 4;
	localparam int SETTLE_CYCLES   = CLK_HZ / 1_000_000 * SETTLE_US;
	localparam int SETTLE_W        = 16;
	localparam logic [15:0] MON_EN_RESET = 16'h0001;

	// ----------------------------------------
	// decoded values
	// ----------------------------------------
	localparam int NET_ADDR_MIN = 1;
	localparam int NET_ADDR_MAX = 31;
	localparam int NET_TENS_MAX = 3;
	localparam int NET_UNITS_MAX = 9;
	localparam int STEPS_FULL = 500;
	localparam int STEPS_HALF = 1000;

	typedef enum logic [3:0] {
		MODE_STORAGE,
		MODE_LOAD_PROG,
		MODE_SERIAL_1200,
		MODE_SERIAL_9600,
		MODE_PAR_ABS,
		MODE_PAR_INC,
		MODE_NET_9600,
		MODE_NET_38K4,
		MODE_SET_ADDR,
		MODE_NONE
	} mode_e;

	// serial character format
	localparam int CHAR_DATA_BITS = 7;
	localparam int CHAR_STOP_BITS = 1;
	localparam logic CHAR_PARITY_EVEN = 1'b1;

	// speed table in Hz
	localparam logic [15:0] SPEED_HZ [16] = '{
		16'h0020, 16'h0064, 16'h01F4, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0FA0, 16'h1388,
		16'h1770, 16'h1F40, 16'h2710, 16'h2EE0, 16'h36B0, 16'h3E80, 16'h4650, 16'h4E20
	};
	// acceleration table in Hz/ms
	localparam logic [15:0] ACCEL_HZMS [16] = '{
		16'h0004, 16'h0006, 16'h000A, 16'h000F, 16'h0014, 16'h001E, 16'h0032, 16'h0064,
		16'h00C8, 16'h012C, 16'h0190, 16'h01F4, 16'h0258, 16'h02BC, 16'h0320, 16'h03E8
	};
	// phase current in units of 10 mA: 75 + 25*code
	localparam logic [8:0] CUR_BASE = 9'h04B;
	localparam logic [8:0] CUR_STEP = 9'h019;

endpackage

// ==== rtl/switch_sync.sv ====
// two-flop synchroniser with a stability filter for one switch group
module switch_sync #(
	parameter int W = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] stable,
	output logic              settled
);
	logic [W-1:0]                              meta;
	logic [W-1:0]                              synced;
	logic [W-1:0]                              last;
	logic [setup_switch_pkg::SETTLE_W-1:0]     count;

	always_ff @(posedge ref_clk) begin
		meta   <= raw;
		synced <= meta;
	end

	// value counts as stable only after it holds for the whole settle time
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			last    <= '0;
			count   <= '0;
			stable  <= '0;
			settled <= 1'b0;
		end else begin
			last <= synced;
			if (synced != last) begin
				count <= '0;
			end else if (count == setup_switch_pkg::SETTLE_W'(setup_switch_pkg::SETTLE_CYCLES - 1)) begin
				stable  <= synced; // RULE20
				settled <= 1'b1;
			end else begin
				count <= count + 1'b1;
			end
		end
	end
endmodule

// ==== rtl/table_lookup.sv ====
// lookup of a 4-bit selector code into a 16-entry value table
module table_lookup (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [3:0]  code,
	input  wire logic        sel_accel,
	output logic      [15:0] value,
	output logic      [3:0]  held
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			value <= '0;
			held  <= '0;
		end else if (load) begin
			held  <= code;
			value <= sel_accel ? setup_switch_pkg::ACCEL_HZMS[code]
			                   : setup_switch_pkg::SPEED_HZ[code];
		end
	end
endmodule

// ==== rtl/stepper_setup_switch_decoder.sv ====
// setup switch decoder for a stepping-motor positioning unit
// Function
// RULE1 - mode selector: 0 store,1 load,2-3 serial,4-5 parallel,6-7 network,8 address
// RULE2 - serial characters: seven data bits, even parity, one stop bit
// RULE3 - speed codes 0..F map to 32 up to 20000 Hz
// RULE4 - speed selector taken only while automatic run input active
// RULE5 - speed may change during automatic run in every mode (code: speed is not loaded in network modes)
// RULE6 - acceleration codes 0..F map to 4 up to 1000 Hz/ms
// RULE7 - acceleration selector taken only while automatic run input active
// RULE8 - acceleration changes during automatic run barred in parallel modes
// RULE9 - network mode: speed selector is tens digit, 0 to 3
// RULE10 - network mode: acceleration selector is units digit, 0 to 9
// RULE11 - network address valid only from 1 to 31
// RULE12 - parameter switch 1 off raises an error
// RULE13 - inhibit input disables rotation monitoring
// RULE14 - inhibit inactive: off command disables, on command enables monitoring
// RULE15 - step-angle switch: full step 500 or half step 1000 per turn
// RULE16 - direction switch picks clockwise or counterclockwise for positive moves
// RULE17 - operator leaves power drive switch 4 off for normal operation
// RULE18 - phase-current codes map 0.75 A to 4.50 A in 0.25 A steps
// RULE19 - mode selector sampled once at power-up only
// RULE20 - switches synchronised and held stable before use
module stepper_setup_switch_decoder (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  modeSelector,
	input  wire logic [3:0]  speedSelector,
	input  wire logic [3:0]  accelSelector,
	input  wire logic [3:0]  currentSelector,
	input  wire logic [3:0]  paramSwitches,
	input  wire logic        automatic_run_input,
	input  wire logic        rotation_monitor_inhibit,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [3:0]  operatingMode,
	output logic             serialEnable,
	output logic      [3:0]  charDataBits,
	output logic             charParityEven,
	output logic      [1:0]  charStopBits,
	output logic      [15:0] runSpeedHz,
	output logic      [15:0] runAccelHzMs,
	output logic      [4:0]  networkAddress,
	output logic             networkAddressValid,
	output logic      [10:0] stepsPerRev,
	output logic             directionCcw,
	output logic             monitorEnable,
	output logic             monitorSwitchError,
	output logic      [8:0]  phaseCurrent10mA
);
	// ----------------------------------------
	// switch synchronisers
	// ----------------------------------------
	logic [3:0]  modeStable;
	logic [3:0]  speedStable;
	logic [3:0]  accelStable;
	logic [3:0]  currentStable;
	logic [3:0]  paramStable;
	logic [1:0]  ctlStable;
	logic [5:0]  settledAll;
	logic [21:0] rawAll;
	logic [21:0] stableAll;

	assign rawAll = {rotation_monitor_inhibit, automatic_run_input, paramSwitches,
	                 currentSelector, accelSelector, speedSelector, modeSelector};
	assign {ctlStable, paramStable, currentStable, accelStable, speedStable, modeStable}
	       = stableAll;

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gSync
			localparam int WG = (g == 5) ? 2 : 4;
			switch_sync #(.W(WG)) uSync (
				.ref_clk (ref_clk),
				.rst     (rst),
				.raw     (rawAll[g*4 +: WG]),
				.stable  (stableAll[g*4 +: WG]),
				.settled (settledAll[g])
			); // RULE20
		end
	endgenerate
	// control pair {inhibit, run} sits in the top two bits

	logic autoRun;
	logic inhibit;
	logic allSettled;
	assign autoRun    = ctlStable[0];
	assign inhibit    = ctlStable[1];
	assign allSettled = &settledAll;

	// ----------------------------------------
	// power-up mode capture
	// ----------------------------------------
	setup_switch_pkg::mode_e mode;
	logic                    modeLatched;
	setup_switch_pkg::mode_e next_mode;

	always_comb begin
		unique case (modeStable) // RULE1
			4'h0: next_mode = setup_switch_pkg::MODE_STORAGE;
			4'h1: next_mode = setup_switch_pkg::MODE_LOAD_PROG;
			4'h2: next_mode = setup_switch_pkg::MODE_SERIAL_1200;
			4'h3: next_mode = setup_switch_pkg::MODE_SERIAL_9600;
			4'h4: next_mode = setup_switch_pkg::MODE_PAR_ABS;
			4'h5: next_mode = setup_switch_pkg::MODE_PAR_INC;
			4'h6: next_mode = setup_switch_pkg::MODE_NET_9600;
			4'h7: next_mode = setup_switch_pkg::MODE_NET_38K4;
			4'h8: next_mode = setup_switch_pkg::MODE_SET_ADDR;
			default: next_mode = setup_switch_pkg::MODE_NONE;
		endcase
	end

	// only the first settled value counts; later turns need a reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode        <= setup_switch_pkg::MODE_NONE;
			modeLatched <= 1'b0;
		end else if (!modeLatched && allSettled) begin
			mode        <= next_mode; // RULE19
			modeLatched <= 1'b1;
		end
	end

	logic isNetwork;
	logic isParallel;
	logic isSerial;
	assign isNetwork  = (mode == setup_switch_pkg::MODE_NET_9600) ||
	                    (mode == setup_switch_pkg::MODE_NET_38K4);
	assign isParallel = (mode == setup_switch_pkg::MODE_PAR_ABS) ||
	                    (mode == setup_switch_pkg::MODE_PAR_INC);
	assign isSerial   = (mode == setup_switch_pkg::MODE_SERIAL_1200) ||
	                    (mode == setup_switch_pkg::MODE_SERIAL_9600);

	// ----------------------------------------
	// speed and acceleration
	// ----------------------------------------
	logic        speedLoad;
	logic        accelLoad;
	logic        accelTaken;
	logic [15:0] speedVal;
	logic [15:0] accelVal;
	logic [3:0]  speedHeld;
	logic [3:0]  accelHeld;

	// speed follows the selector throughout automatic run, except in network modes
	assign speedLoad = modeLatched && autoRun && !isNetwork; // RULE4 RULE5
	// parallel modes freeze acceleration once a run has taken it
	assign accelLoad = modeLatched && autoRun && !isNetwork &&
	                   !(isParallel && accelTaken); // RULE7 RULE8

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			accelTaken <= 1'b0;
		end else begin
			accelTaken <= autoRun && modeLatched;
		end
	end

	table_lookup uSpeed (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.load      (speedLoad),
		.code      (speedStable),
		.sel_accel (1'b0),
		.value     (speedVal),
		.held      (speedHeld)
	); // RULE3

	table_lookup uAccel (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.load      (accelLoad),
		.code      (accelStable),
		.sel_accel (1'b1),
		.value     (accelVal),
		.held      (accelHeld)
	); // RULE6

	// ----------------------------------------
	// network address
	// ----------------------------------------
	logic [5:0] next_addr;
	logic       next_addrOk;

	always_comb begin
		next_addr   = 6'(speedStable[1:0]) * 6'd10 + 6'(accelStable); // RULE9 RULE10
		next_addrOk = (speedStable <= 4'(setup_switch_pkg::NET_TENS_MAX)) &&
		              (accelStable <= 4'(setup_switch_pkg::NET_UNITS_MAX)) &&
		              (next_addr >= 6'(setup_switch_pkg::NET_ADDR_MIN)) &&
		              (next_addr <= 6'(setup_switch_pkg::NET_ADDR_MAX)); // RULE11
	end

	// ----------------------------------------
	// rotation monitoring and parameter switches
	// ----------------------------------------
	logic monOffCmd;
	logic monOnCmd;
	logic monCmdState;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			monCmdState <= setup_switch_pkg::MON_EN_RESET[0];
		end else if (!inhibit) begin
			if (monOffCmd) begin
				monCmdState <= 1'b0; // RULE14
			end else if (monOnCmd) begin
				monCmdState <= 1'b1; // RULE14
			end
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			operatingMode       <= 4'hF;
			serialEnable        <= 1'b0;
			charDataBits        <= '0;
			charParityEven      <= 1'b0;
			charStopBits        <= '0;
			runSpeedHz          <= '0;
			runAccelHzMs        <= '0;
			networkAddress      <= '0;
			networkAddressValid <= 1'b0;
			stepsPerRev         <= '0;
			directionCcw        <= 1'b0;
			monitorEnable       <= 1'b0;
			monitorSwitchError  <= 1'b0;
			phaseCurrent10mA    <= '0;
		end else begin
			operatingMode  <= modeLatched ? 4'(mode) : 4'hF;
			serialEnable   <= isSerial;
			charDataBits   <= 4'(setup_switch_pkg::CHAR_DATA_BITS); // RULE2
			charParityEven <= setup_switch_pkg::CHAR_PARITY_EVEN; // RULE2
			charStopBits   <= 2'(setup_switch_pkg::CHAR_STOP_BITS); // RULE2
			runSpeedHz     <= speedVal;
			runAccelHzMs   <= accelVal;
			if (isNetwork) begin
				networkAddress      <= next_addr[4:0];
				networkAddressValid <= next_addrOk && allSettled;
			end else begin
				networkAddressValid <= 1'b0;
			end
			stepsPerRev  <= paramStable[1] ? 11'(setup_switch_pkg::STEPS_HALF)
			                               : 11'(setup_switch_pkg::STEPS_FULL); // RULE15
			directionCcw <= paramStable[2]; // RULE16
			monitorEnable <= !inhibit && monCmdState && paramStable[0]; // RULE13
			monitorSwitchError <= allSettled && !paramStable[0]; // RULE12
			phaseCurrent10mA <= setup_switch_pkg::CUR_BASE +
			                    9'(currentStable) * setup_switch_pkg::CUR_STEP; // RULE18
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic [7:0]  wAddr;
	logic        wAddrHave;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        wDataHave;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			wAddrHave     <= 1'b0;
			wDataHave     <= 1'b0;
			wAddr         <= '0;
			wData         <= '0;
			wStrb         <= '0;
			monOffCmd     <= 1'b0;
			monOnCmd      <= 1'b0;
		end else begin
			monOffCmd     <= 1'b0;
			monOnCmd      <= 1'b0;
			s_axi_awready <= !wAddrHave && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !wDataHave && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				wAddr     <= s_axi_awaddr;
				wAddrHave <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData     <= s_axi_wdata;
				wStrb     <= s_axi_wstrb;
				wDataHave <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wAddrHave && wDataHave && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wAddr == setup_switch_pkg::ADDR_CTRL) ? 2'h0 : 2'h2;
				if (wAddr == setup_switch_pkg::ADDR_CTRL && wStrb[0]) begin
					monOffCmd <= wData[setup_switch_pkg::CTRL_MON_OFF_BIT];
					monOnCmd  <= wData[setup_switch_pkg::CTRL_MON_ON_BIT];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				wAddrHave    <= 1'b0;
				wDataHave    <= 1'b0;
			end
		end
	end

	logic [31:0] next_rdata;
	logic        next_rok;

	always_comb begin
		next_rdata = '0;
		next_rok   = 1'b1;
		unique case (s_axi_araddr)
			setup_switch_pkg::ADDR_CTRL:    next_rdata = '0;
			setup_switch_pkg::ADDR_MODE:    next_rdata = {20'h0, charDataBits, 4'h0, operatingMode};
			setup_switch_pkg::ADDR_RUN:     next_rdata = {runAccelHzMs, runSpeedHz};
			setup_switch_pkg::ADDR_NETADDR: next_rdata = {26'h0, networkAddressValid,
			                                              networkAddress};
			setup_switch_pkg::ADDR_DRIVE:   next_rdata = {21'h0, paramStable[3], directionCcw,
			                                              stepsPerRev == 11'(setup_switch_pkg::STEPS_HALF),
			                                              phaseCurrent10mA[7:0]};
			setup_switch_pkg::ADDR_STATUS:  next_rdata = {27'h0, modeLatched, allSettled,
			                                              networkAddressValid,
			                                              monitorSwitchError, monitorEnable};
			default: next_rok = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b1
			               : (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready));
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= next_rdata;
				s_axi_rresp   <= next_rok ? 2'h0 : 2'h2;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ==== sim/setup_switch_monitor.sv ====
// checker: concurrent properties on the setup switch decoder ports
module setup_switch_monitor (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [3:0]  paramSwitches,
	input wire logic        rotation_monitor_inhibit,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic [3:0]  operatingMode,
	input wire logic        serialEnable,
	input wire logic [3:0]  charDataBits,
	input wire logic        charParityEven,
	input wire logic [1:0]  charStopBits,
	input wire logic [15:0] runSpeedHz,
	input wire logic [15:0] runAccelHzMs,
	input wire logic [4:0]  networkAddress,
	input wire logic        networkAddressValid,
	input wire logic [10:0] stepsPerRev,
	input wire logic        monitorEnable,
	input wire logic        monitorSwitchError,
	input wire logic [8:0]  phaseCurrent10mA
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	// margin over the filter span so a slow settle never trips the error check
	localparam int SW_ON_LIMIT = setup_switch_pkg::SETTLE_CYCLES + 8;
	logic [16:0] swOnCount;
	logic [16:0] inhQuietCount;
	logic [7:0]  lastAddr;
	logic [31:0] lastData;
	always_ff @(posedge ref_clk) begin
		if (rst || !paramSwitches[0]) swOnCount <= 17'h00000;
		else if (swOnCount != 17'h1FFFF) swOnCount <= swOnCount + 17'h00001;
	end
	// inhibit passes the same filter, so commands count only once it has settled low
	always_ff @(posedge ref_clk) begin
		if (rst || rotation_monitor_inhibit) inhQuietCount <= 17'h00000;
		else if (inhQuietCount != 17'h1FFFF) inhQuietCount <= inhQuietCount + 17'h00001;
	end
	always_ff @(posedge ref_clk) begin
		if (s_axi_awvalid && s_axi_awready) lastAddr <= s_axi_awaddr;
	end
	always_ff @(posedge ref_clk) begin
		if (s_axi_wvalid && s_axi_wready) lastData <= s_axi_wdata;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence quietInhibit;
		inhQuietCount >= SW_ON_LIMIT;
	endsequence
	sequence ctrlDone;
		$rose(s_axi_bvalid) && s_axi_bresp == 2'h0 && lastAddr == setup_switch_pkg::ADDR_CTRL;
	endsequence
	a_serial_format: assert property (serialEnable |-> charDataBits == 4'h7 && charParityEven
		&& charStopBits == 2'h1) else $error("serial character format wrong");
	a_serial_mode: assert property (serialEnable |-> operatingMode inside {4'h2, 4'h3})
		else $error("serial enable outside serial modes");
	a_net_range: assert property (networkAddressValid |-> networkAddress >= 5'h01
		&& operatingMode inside {4'h6, 4'h7}) else $error("network address accepted wrongly");
	a_speed_table: assert property (runSpeedHz != 16'h0000
		|-> runSpeedHz inside {setup_switch_pkg::SPEED_HZ}) else $error("speed not in table");
	a_accel_table: assert property (runAccelHzMs != 16'h0000
		|-> runAccelHzMs inside {setup_switch_pkg::ACCEL_HZMS}) else $error("accel not in table");
	a_current_steps: assert property (phaseCurrent10mA != 9'h000 |-> phaseCurrent10mA >= 9'h04B
		&& phaseCurrent10mA <= 9'h1C2 && (phaseCurrent10mA - 9'h04B) % 9'h019 == 9'h000)
		else $error("phase current off the 0.25 A grid");
	a_step_angle: assert property (stepsPerRev inside {11'h000, 11'h1F4, 11'h3E8})
		else $error("steps per turn not 500 or 1000");
	a_mode_frozen: assert property ($past(operatingMode) != 4'hF |-> $stable(operatingMode))
		else $error("mode changed after latching");
	a_monitor_off: assert property (quietInhibit ##0 (ctrlDone and lastData[0])
		|-> ##[1:4] !monitorEnable) else $error("monitor off command ignored");
	a_monitor_on: assert property (quietInhibit ##0 (ctrlDone and (lastData[1:0] == 2'h2
		&& swOnCount >= SW_ON_LIMIT)) |-> ##[1:4] monitorEnable)
		else $error("monitor on command ignored");
	a_sw1_error: assert property (swOnCount >= SW_ON_LIMIT |-> !monitorSwitchError)
		else $error("switch error with monitor switch on");
endmodule

bind stepper_setup_switch_decoder setup_switch_monitor mon_u (.*);

// ==== sim/setup_panel_model.sv ====
// partner model: operator setup switches and automation controller lines
module setup_panel_model (
	input  wire logic       ref_clk,
	output logic      [3:0] modeSelector,
	output logic      [3:0] speedSelector,
	output logic      [3:0] accelSelector,
	output logic      [3:0] currentSelector,
	output logic      [3:0] paramSwitches,
	output logic            automatic_run_input,
	output logic            rotation_monitor_inhibit
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{modeSelector, speedSelector, accelSelector, currentSelector, paramSwitches} = 20'h00000;
		{automatic_run_input, rotation_monitor_inhibit} = 2'h0;
	end
	// switches move on an edge and then rest; the operator never bounces them
	task automatic setSwitches(input logic [3:0] m, s, a, c, input logic [2:0] p);
		@(posedge ref_clk);
		modeSelector <= m;
		speedSelector <= s;
		accelSelector <= a;
		currentSelector <= c;
		paramSwitches <= {1'b0, p};
	endtask
	task automatic setLines(input logic run, inh);
		@(posedge ref_clk);
		automatic_run_input <= run;
		rotation_monitor_inhibit <= inh;
	endtask
endmodule

// ==== sim/stepper_setup_switch_decoder_bench.sv ====
// testbench: setup switch decoder driven through its switches and register bus
module stepper_setup_switch_decoder_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  modeSelector, speedSelector, accelSelector, currentSelector, paramSwitches;
	logic        automatic_run_input, rotation_monitor_inhibit;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp, charStopBits;
	logic [3:0]  operatingMode, charDataBits;
	logic        serialEnable, charParityEven, networkAddressValid, directionCcw;
	logic        monitorEnable, monitorSwitchError;
	logic [15:0] runSpeedHz, runAccelHzMs;
	logic [4:0]  networkAddress;
	logic [10:0] stepsPerRev;
	logic [8:0]  phaseCurrent10mA;
	logic [1:0]  cmds [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
	int          n_errors = 0;
	int          n_compared = 0;

	stepper_setup_switch_decoder dut_u (.*);
	setup_panel_model panel_u (.*);

	initial forever #50 ref_clk = ~ref_clk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axiRead(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdata = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// the filter span is fixed in the package, so every phase waits it out
	task automatic settle();
		repeat (setup_switch_pkg::SETTLE_CYCLES + 16) @(posedge ref_clk);
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		// serial mode, monitor switch on, half step, ccw, auto run idle
		panel_u.setSwitches(4'h2, 4'hF, 4'h0, 4'hF, 3'b111);
		panel_u.setLines(1'b0, 1'b0);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		settle();
		check(operatingMode, 4'h2);
		check(serialEnable, 1'b1);
		check({charDataBits, charParityEven, charStopBits}, {4'h7, 1'b1, 2'h1});
		check(runSpeedHz, 16'h0000);
		check(runAccelHzMs, 16'h0000);
		check(stepsPerRev, 11'h3E8);
		check(directionCcw, 1'b1);
		check(monitorSwitchError, 1'b0);
		check(phaseCurrent10mA, 9'h1C2);
		axiRead(8'h04);
		check({resp, rdata}, {2'h0, 32'h0000_0702});
		axiRead(8'h18);
		check({resp, rdata}, {2'h2, 32'h0000_0000});
		axiWrite(8'h04, 32'h0000_0003);
		check(resp, 2'h2);
		foreach (cmds[i]) begin
			axiWrite(8'h00, {30'h0, cmds[i]});
			repeat (4) @(posedge ref_clk);
			check(monitorEnable, !cmds[i][0]);
		end
		panel_u.setLines(1'b0, 1'b1);
		for (int i = 0; i < setup_switch_pkg::SETTLE_CYCLES + 16; i++) begin
			if (monitorEnable === 1'b0) break;
			@(posedge ref_clk);
		end
		check(monitorEnable, 1'b0);
		axiWrite(8'h00, 32'h0000_0002);
		repeat (4) @(posedge ref_clk);
		check(monitorEnable, 1'b0);
		// mode moved after latching; auto run starts with new selectors
		panel_u.setSwitches(4'h4, 4'h3, 4'h1, 4'hF, 3'b000);
		panel_u.setLines(1'b1, 1'b1);
		settle();
		check(operatingMode, 4'h2);
		check(runSpeedHz, 16'h03E8);
		check(runAccelHzMs, 16'h0006);
		check({stepsPerRev, directionCcw}, {11'h1F4, 1'b0});
		check(monitorSwitchError, 1'b1);
		// network mode at the top address
		rst <= 1'b1;
		panel_u.setSwitches(4'h6, 4'h3, 4'h1, 4'h0, 3'b001);
		panel_u.setLines(1'b1, 1'b0);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		settle();
		check(operatingMode, 4'h6);
		check({networkAddressValid, networkAddress}, {1'b1, 5'h1F});
		check(runSpeedHz, 16'h0000);
		check(phaseCurrent10mA, 9'h04B);
		axiRead(8'h0C);
		check({resp, rdata}, {2'h0, 32'h0000_003F});
		// parallel mode: speed follows a run, acceleration keeps its first value
		rst <= 1'b1;
		panel_u.setSwitches(4'h4, 4'h2, 4'h2, 4'h0, 3'b001);
		panel_u.setLines(1'b1, 1'b0);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		settle();
		check(runAccelHzMs, 16'h000A);
		panel_u.setSwitches(4'h4, 4'h5, 4'h7, 4'h0, 3'b001);
		settle();
		check(operatingMode, 4'h4);
		check(runSpeedHz, 16'h0BB8);
		check(runAccelHzMs, 16'h000A);
		end_of_test();
	end
	initial begin
		repeat (3 * setup_switch_pkg::SETTLE_CYCLES + 10000) @(posedge ref_clk);
		n_errors++;
		$display("Error %0t: run did not finish", $time);
		end_of_test();
	end
endmodule
